// File: hdl/wmfc_pkg.sv
// Package for the working mode and fault controller.
// Holds modes, command codes, error codes and timing constants.
package wmfc_pkg;
    typedef enum logic [1:0] {
        MODE_INIT,
        MODE_NORMAL,
        MODE_SESSION,
        MODE_FAULT
    } wmfc_mode_t;

    localparam logic [15:0] CMD_ENTER_SESSION = 16'h72d1;
    localparam logic [15:0] CMD_NVM_UNLOCK = 16'h00a5;
    localparam logic [15:0] CMD_REINIT = 16'h00c3;
    localparam logic [15:0] CMD_MEASURE = 16'h0062;
    localparam logic [15:0] CMD_LEAVE_SESSION = 16'h0099;
    localparam logic [15:0] CMD_NVM_WRITE = 16'h0080;

    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_RAM_PARITY = 16'hc001;
    localparam logic [15:0] ERR_NVM = 16'hc004;
    localparam logic [15:0] ERR_WATCHDOG = 16'hc008;
    localparam logic [15:0] ERR_SENSOR = 16'hc010;

    localparam int START_WDG_CLOCKS = 69632;
    localparam int CONV_CYCLE_NS = 1000000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int CONV_CYCLE_CLOCKS = CONV_CYCLE_NS / CLK_PERIOD_NS;
    localparam int MEAS_WDG_CLOCKS = 2 * CONV_CYCLE_CLOCKS;
    localparam int FAIL_ENTER_COUNT = 2;
    localparam int NVM_WORDS = 32;
    localparam int NVM_AW = 5;
    localparam int CFG_CHK_TEMP = 0;
    localparam int CFG_CHK_SENS = 1;
    localparam int CFG_CHK_AGING = 2;
    localparam int CFG_CHK_ROM = 3;
    localparam int CFG_OWI_WINDOW = 4;
    localparam logic [15:0] ONE_WIRE_WINDOW_CLOCKS = 16'hffff;
endpackage

// File: hdl/wmfc_fail_counter.sv
// Failure counter for counted checks (temporary fault mode).
// Expects one check result strobe per measurement cycle.
`timescale 1ns/1ns
`default_nettype none
module wmfc_fail_counter
    import wmfc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Check result
    input wire logic checkValid,
    input wire logic checkFail,
    input wire logic clearAll,
    // Fault state
    output logic active
);
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic active_reg;
    logic active_next;
    localparam logic [1:0] LIMIT = 2'(FAIL_ENTER_COUNT);

    assign count_next = clearAll ? 2'h0 :
        !checkValid ? count_reg :
        checkFail ? ((count_reg == LIMIT) ? count_reg : count_reg + 2'h1) :
        ((count_reg == 2'h0) ? count_reg : count_reg - 2'h1);
    assign active_next = clearAll ? 1'b0 :
        (count_next == LIMIT) ? 1'b1 :
        (count_next == 2'h0) ? 1'b0 : active_reg;
    assign active = active_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= 2'h0;
            active_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            active_reg <= active_next;
        end
    end
endmodule
`default_nettype wire

// File: hdl/wmfc_temp_check.sv
// Temperature raw value range check.
// Raw value is right aligned at the resolution given by resBits.
`timescale 1ns/1ns
`default_nettype none
module wmfc_temp_check
    import wmfc_pkg::*;
(
    // Raw value and resolution (13 to 16)
    input wire logic [15:0] rawTemp,
    input wire logic [4:0] resBits,
    // Result
    output logic fail
);
    logic [15:0] shifted;
    logic [4:0] effRes;
    logic [15:0] limit;

    // Wide conversions are reduced by two bits before the check.
    assign shifted = (resBits >= 5'h0f) ? (rawTemp >> 2) : rawTemp;
    assign effRes = (resBits >= 5'h0f) ? resBits - 5'h02 : resBits;
    assign limit = (16'h0001 << effRes) - 16'h0001;
    assign fail = (shifted == 16'h0000) || (shifted >= limit);
endmodule
`default_nettype wire

// File: hdl/wmfc_top.sv
// Working mode and fault controller of the signal conditioner.
// Assumes the serial ports deliver whole command words as one-cycle
// strobes on clk, and that the NVM and RAM answer one word per cycle.
//
// Overview of operation
// - Mirror NVM to RAM at power-on and reinit.
// - RAM parity error enters fault mode.
// - Three working modes, switched by commands.
// - Initialise then enter normal mode unaided.
// - Mirror verifies NVM; error forces fault mode.
// - Result updates each cycle, drives output.
// - Host result reads never disturb conditioning.
// - Enter-session command stops measurement cycle.
// - Session entered only by that command.
// - Other commands in normal mode discarded.
// - Session mode runs the full command set.
// - Port disabled while a command runs.
// - After command wait, or loop measurements.
// - NVM writes blocked until unlock command.
// - Session entry over I2C always allowed.
// - One-wire entry obeys configured start window outside fault mode.
// - Fault mode: low band, error code, ports.
// - Configuration enables fault checks individually.
// - Two failures enter, countdown leaves fault.
// - Temperature raw 0 or full scale fails.
// - 16/15-bit raw shifted to 14/13 bits.
// - Simultaneous C0xx codes are ORed.
// - Watchdog code replaces signature/config codes.
// - Watchdog on start and measurement overrun.
// - RAM parity reported at once as C001.
`timescale 1ns/1ns
`default_nettype none
module wmfc_top
    import wmfc_pkg::*;
#(
    parameter int START_WDG = START_WDG_CLOCKS,
    parameter int MEAS_WDG = MEAS_WDG_CLOCKS,
    parameter int CONV_CYCLE = CONV_CYCLE_CLOCKS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Commands from the serial host port
    input wire logic cmdValid,
    input wire logic [15:0] cmdWord,
    input wire logic cmdFromOneWire,
    output logic cmdReady,
    // Command routine completion from the conditioning core
    input wire logic cmdDone,
    output logic cmdStart,
    output logic [15:0] cmdActive,
    // NVM read and write
    output logic [NVM_AW-1:0] nvmAddr,
    output logic nvmRead,
    input wire logic [15:0] nvmData,
    input wire logic nvmError,
    output logic nvmWriteEn,
    // RAM parity check of every read
    input wire logic ramRead,
    input wire logic ramParityBad,
    // Measurement cycle
    input wire logic measDone,
    input wire logic [15:0] result,
    input wire logic [15:0] rawTemp,
    input wire logic [4:0] resBits,
    input wire logic sensFail,
    input wire logic agingFail,
    input wire logic romFail,
    output logic measRun,
    // Outputs
    output logic [15:0] analogLevel,
    output logic lowerFaultBand,
    output logic [15:0] serialOut,
    output logic oneWireEnable,
    output logic i2cEnable,
    output wmfc_mode_t mode
);
    wmfc_mode_t mode_reg, mode_next;
    logic [NVM_AW-1:0] addr_reg, addr_next;
    logic [15:0] cfg_reg, cfg_next;
    logic initFail_reg, initFail_next;
    logic busy_reg, busy_next;
    logic loop_reg, loop_next;
    logic unlock_reg, unlock_next;
    logic [15:0] cmd_reg, cmd_next;
    logic [15:0] err_reg, err_next;
    logic [16:0] wdg_reg, wdg_next;
    logic [15:0] win_reg, win_next;
    logic [15:0] result_reg, result_next;
    logic [15:0] out_reg, out_next;
    logic parity_reg, parity_next;
    logic [15:0] cmdIn;

    logic isEnter, isReinit, isLeave, isUnlock, isMeasure, isNvmWrite;
    logic portOpen, entryAllowed, takeCmd;
    logic mirrorLast, wdgTimeout, tempFail, countedFault;
    logic checkTemp, checkSens, checkAging, failCheck;
    logic [15:0] sensorCode, faultCode;

    function automatic logic cmd_is(input logic [15:0] w,
                                    input logic [15:0] c);
        cmd_is = (w == c);
    endfunction

    assign cmdIn = cmdWord;
    assign isEnter = cmd_is(cmdIn, CMD_ENTER_SESSION);
    assign isReinit = cmd_is(cmdIn, CMD_REINIT);
    assign isLeave = cmd_is(cmdIn, CMD_LEAVE_SESSION);
    assign isUnlock = cmd_is(cmdIn, CMD_NVM_UNLOCK);
    assign isMeasure = cmd_is(cmdIn, CMD_MEASURE);
    assign isNvmWrite = cmd_is(cmdIn, CMD_NVM_WRITE);

    // The port is closed during init and while a command is running.
    assign portOpen = (mode_reg != MODE_INIT) && !busy_reg;
    assign cmdReady = portOpen;
    // One-wire entry only while its start window lasts, unless the
    // window option is off or in fault mode; I2C entry is always open.
    assign entryAllowed = !cmdFromOneWire ||
        !cfg_reg[CFG_OWI_WINDOW] || (win_reg != 16'h0000) ||
        (mode_reg == MODE_FAULT);
    assign takeCmd = cmdValid && portOpen;

    assign mirrorLast = (addr_reg == NVM_AW'(NVM_WORDS - 1));
    assign checkTemp = cfg_reg[CFG_CHK_TEMP];
    assign checkSens = cfg_reg[CFG_CHK_SENS];
    assign checkAging = cfg_reg[CFG_CHK_AGING];
    assign sensorCode = ((checkSens && sensFail) ||
        (checkAging && agingFail) ||
        (checkTemp && tempFail)) ? ERR_SENSOR : ERR_NONE;
    assign wdgTimeout = (mode_reg == MODE_INIT) ?
        (wdg_reg >= 17'(START_WDG)) :
        (measRun && (wdg_reg >= 17'(MEAS_WDG)));

    wmfc_temp_check tempCheck (
        .rawTemp(rawTemp),
        .resBits(resBits),
        .fail(tempFail)
    );

    // Checks keep running in fault mode so the counter can count down.
    assign failCheck = measDone &&
        (mode_reg == MODE_NORMAL || mode_reg == MODE_FAULT);

    wmfc_fail_counter failCounter (
        .clk(clk),
        .nrst(nrst),
        .checkValid(failCheck),
        .checkFail(sensorCode != ERR_NONE),
        .clearAll(mode_reg == MODE_INIT),
        .active(countedFault)
    );

    // Sensor codes are ORed in; the watchdog code wins over the rest.
    assign faultCode = wdgTimeout ? ERR_WATCHDOG :
        (err_reg | (parity_reg ? ERR_RAM_PARITY : ERR_NONE) |
        (countedFault ? sensorCode : ERR_NONE));

    always_comb begin
        mode_next = mode_reg;
        addr_next = addr_reg;
        cfg_next = cfg_reg;
        initFail_next = initFail_reg;
        busy_next = busy_reg;
        loop_next = loop_reg;
        unlock_next = unlock_reg;
        cmd_next = cmd_reg;
        err_next = err_reg;
        win_next = (win_reg != 16'h0000) ? win_reg - 16'h0001 : win_reg;
        parity_next = parity_reg | (ramRead && ramParityBad);
        unique case (mode_reg)
            MODE_INIT: begin
                // The mirror checks every word and applies the first
                // one as configuration.
                addr_next = addr_reg + NVM_AW'(1);
                if (addr_reg == NVM_AW'(0)) begin
                    cfg_next = nvmData;
                end
                initFail_next = initFail_reg | nvmError;
                if (mirrorLast) begin
                    addr_next = NVM_AW'(0);
                    mode_next = (initFail_reg || nvmError ||
                        (cfg_reg[CFG_CHK_ROM] && romFail)) ?
                        MODE_FAULT : MODE_NORMAL;
                    if (initFail_reg || nvmError) begin
                        err_next = err_reg | ERR_NVM;
                    end
                end
            end
            MODE_NORMAL: begin
                // Result reads go to the port only; only entry acts.
                if (takeCmd && isEnter && entryAllowed) begin
                    mode_next = MODE_SESSION;
                end
                if (countedFault) begin
                    mode_next = MODE_FAULT;
                end
            end
            MODE_SESSION: begin
                if (takeCmd) begin
                    cmd_next = cmdIn;
                    busy_next = 1'b1;
                    loop_next = isMeasure;
                    if (isUnlock) begin
                        unlock_next = 1'b1;
                    end
                    if (isReinit) begin
                        mode_next = MODE_INIT;
                        busy_next = 1'b0;
                    end
                    if (isLeave) begin
                        mode_next = MODE_NORMAL;
                        busy_next = 1'b0;
                        unlock_next = 1'b0;
                    end
                end else if (busy_reg && cmdDone) begin
                    busy_next = loop_reg;
                end
            end
            MODE_FAULT: begin
                if (takeCmd && isEnter) begin
                    mode_next = MODE_SESSION;
                    err_next = ERR_NONE;
                    parity_next = ramRead && ramParityBad;
                end else if (!countedFault && err_reg == ERR_NONE &&
                             !parity_reg && !wdgTimeout) begin
                    mode_next = MODE_NORMAL;
                end
            end
            default: begin
                mode_next = MODE_INIT;
            end
        endcase
        if (parity_next) begin
            mode_next = MODE_FAULT;
        end
        if (wdgTimeout) begin
            mode_next = MODE_FAULT;
            err_next = ERR_WATCHDOG;
        end
        if (mode_next != MODE_SESSION) begin
            busy_next = 1'b0;
            loop_next = 1'b0;
        end
    end

    assign wdg_next = (mode_reg != mode_next || measDone ||
        (mode_reg != MODE_INIT && !measRun)) ? 17'h00000 :
        (wdgTimeout ? wdg_reg : wdg_reg + 17'h00001);
    assign result_next = (measDone && mode_reg == MODE_NORMAL) ?
        result : result_reg;
    assign out_next = (mode_reg == MODE_FAULT) ? faultCode :
        result_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= MODE_INIT;
            addr_reg <= NVM_AW'(0);
            cfg_reg <= 16'h0000;
            initFail_reg <= 1'b0;
            busy_reg <= 1'b0;
            loop_reg <= 1'b0;
            unlock_reg <= 1'b0;
            cmd_reg <= 16'h0000;
            err_reg <= ERR_NONE;
            wdg_reg <= 17'h00000;
            win_reg <= ONE_WIRE_WINDOW_CLOCKS;
            result_reg <= 16'h0000;
            out_reg <= 16'h0000;
            parity_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            addr_reg <= addr_next;
            cfg_reg <= cfg_next;
            initFail_reg <= (mode_next == MODE_INIT) ? initFail_next : 1'b0;
            busy_reg <= busy_next;
            loop_reg <= loop_next;
            unlock_reg <= unlock_next;
            cmd_reg <= cmd_next;
            err_reg <= err_next;
            wdg_reg <= wdg_next;
            win_reg <= win_next;
            result_reg <= result_next;
            out_reg <= out_next;
            parity_reg <= parity_next;
        end
    end

    assign nvmAddr = addr_reg;
    assign nvmRead = (mode_reg == MODE_INIT);
    assign nvmWriteEn = unlock_reg && busy_reg &&
        cmd_is(cmd_reg, CMD_NVM_WRITE);
    assign cmdStart = takeCmd && mode_reg == MODE_SESSION;
    assign cmdActive = cmd_reg;
    // Measurement runs in normal mode and for looping session commands.
    assign measRun = (mode_reg == MODE_NORMAL) ||
        (mode_reg == MODE_SESSION && loop_reg);
    assign lowerFaultBand = (mode_reg == MODE_FAULT);
    assign analogLevel = (mode_reg == MODE_FAULT) ? 16'h0000 : result_reg;
    assign serialOut = out_reg;
    assign oneWireEnable = (mode_reg == MODE_FAULT) ||
        !cfg_reg[CFG_OWI_WINDOW] || (win_reg != 16'h0000);
    assign i2cEnable = 1'b1;
    assign mode = mode_reg;
endmodule
`default_nettype wire

// File: tb/wmfc_top_properties.sv
// Concurrent checks of mode, command and fault behaviour.
// Bound into wmfc_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module wmfc_top_chk
    import wmfc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Watched signals
    input wire logic cmdValid,
    input wire logic [15:0] cmdWord,
    input wire logic cmdReady,
    input wire logic cmdStart,
    input wire logic [NVM_AW-1:0] nvmAddr,
    input wire logic nvmRead,
    input wire logic nvmWriteEn,
    input wire logic ramRead,
    input wire logic ramParityBad,
    input wire logic measDone,
    input wire logic measRun,
    input wire logic [15:0] analogLevel,
    input wire logic lowerFaultBand,
    input wire logic [15:0] serialOut,
    input wire logic oneWireEnable,
    input wire logic i2cEnable,
    input wire wmfc_mode_t mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic take = cmdValid && cmdReady;
    wire logic enter = take && (cmdWord == CMD_ENTER_SESSION);
    logic unlock_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) unlock_reg <= 1'b0;
        else if (cmdStart && cmdWord == CMD_NVM_UNLOCK) unlock_reg <= 1'b1;
        else if (cmdStart && cmdWord == CMD_LEAVE_SESSION) unlock_reg <= 1'b0;
    end
    init_leave_a: assert property ($rose(nrst) |-> ##[1:40]
        mode != MODE_INIT) else $error("init did not finish");
    mirror_step_a: assert property (mode == MODE_INIT && nvmRead ##1
        mode == MODE_INIT && nvmRead |-> nvmAddr == $past(nvmAddr) + 5'h01)
        else $error("mirror address did not step");
    session_entry_a: assert property (enter && mode == MODE_NORMAL |=>
        mode == MODE_SESSION && !measRun) else $error("no session entry");
    session_only_a: assert property (mode != MODE_SESSION ##1
        mode == MODE_SESSION |-> $past(enter)) else $error("bad entry");
    normal_ignore_a: assert property (take && mode == MODE_NORMAL &&
        cmdWord != CMD_ENTER_SESSION && !ramParityBad && !measDone |=>
        mode == MODE_NORMAL && measRun) else $error("command not ignored");
    busy_refuse_a: assert property (cmdStart && cmdWord == CMD_MEASURE |=>
        (!cmdReady && measRun) [*3]) else $error("busy port took command");
    nvm_lock_a: assert property (nvmWriteEn |-> unlock_reg)
        else $error("nvm write while locked");
    parity_fault_a: assert property (mode == MODE_NORMAL && ramRead &&
        ramParityBad |=> mode == MODE_FAULT ##1
        (serialOut & ERR_RAM_PARITY) == ERR_RAM_PARITY)
        else $error("parity fault not reported");
    fault_out_a: assert property (mode == MODE_FAULT |-> lowerFaultBand &&
        analogLevel == 16'h0000 && oneWireEnable && i2cEnable)
        else $error("fault outputs wrong");
    cover property (enter);
    cover property (mode == MODE_FAULT);
    cover property (nvmWriteEn);
endmodule
bind wmfc_top wmfc_top_chk chk (.clk(clk), .nrst(nrst),
    .cmdValid(cmdValid), .cmdWord(cmdWord), .cmdReady(cmdReady),
    .cmdStart(cmdStart), .nvmAddr(nvmAddr), .nvmRead(nvmRead),
    .nvmWriteEn(nvmWriteEn), .ramRead(ramRead),
    .ramParityBad(ramParityBad), .measDone(measDone), .measRun(measRun),
    .analogLevel(analogLevel), .lowerFaultBand(lowerFaultBand),
    .serialOut(serialOut), .oneWireEnable(oneWireEnable),
    .i2cEnable(i2cEnable), .mode(mode));
`default_nettype wire

// File: tb/wmfc_core_model.sv
// Model of the NVM and conditioning core beside the controller.
// Drives its outputs at the falling edge of clk.
`timescale 1ns/1ns
`default_nettype none
module wmfc_core_model
    import wmfc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Test controls
    input wire logic [15:0] cfgWord,
    input wire logic badWord,
    input wire logic stall,
    // Memory side
    input wire logic [NVM_AW-1:0] nvmAddr,
    input wire logic nvmRead,
    output logic [15:0] nvmData,
    output logic nvmError,
    // Core side
    input wire logic cmdStart,
    input wire logic [15:0] cmdActive,
    input wire logic measRun,
    input wire logic lowerFaultBand,
    output logic cmdDone,
    output logic measDone
);
    logic [4:0] cnt = 5'h00;
    logic [1:0] left = 2'h0;
    logic gotStart = 1'b0;
    initial begin
        nvmData = 16'h0000;
        nvmError = 1'b0;
        cmdDone = 1'b0;
        measDone = 1'b0;
    end
    always @(posedge clk) gotStart <= cmdStart;
    always @(negedge clk) begin
        // A released data bus shows the inverse of its last word.
        nvmData = !nvmRead ? ~nvmData : nvmAddr == 5'h00 ? cfgWord
            : {11'h000, nvmAddr};
        nvmError = badWord && nvmRead && nvmAddr == 5'h03;
        measDone = 1'b0;
        cmdDone = 1'b0;
        if ((measRun || lowerFaultBand) && !stall && nrst) begin
            cnt = cnt + 5'h01;
            measDone = (cnt == 5'h14);
            if (measDone) cnt = 5'h00;
        end
        if (gotStart) left = 2'h3;
        else if (left != 2'h0) begin
            left = left - 2'h1;
            cmdDone = left == 2'h0 && cmdActive != CMD_MEASURE;
        end
    end
endmodule
`default_nettype wire

// File: tb/wmfc_top_tb.sv
// Self-checking bench of the mode and fault controller.
// The core model answers memory reads and command completion.
`timescale 1ns/1ns
`default_nettype none
module wmfc_top_tb import wmfc_pkg::*; ;
    logic clk, nrst = 1'b0, cmdValid = 1'b0, cmdFromOneWire = 1'b0;
    logic ramRead = 1'b0, ramParityBad = 1'b0, badWord = 1'b0;
    logic stall = 1'b0, cmdDone, measDone, nvmError, cmdReady, cmdStart;
    logic nvmRead, nvmWriteEn, measRun, lowerFaultBand, oneWireEnable;
    logic i2cEnable;
    logic sensFail = 1'b0, agingFail = 1'b0, romFail = 1'b0;
    logic [15:0] cmdWord = 16'h0000, result = 16'h0000;
    logic [15:0] rawTemp = 16'h2000, cfgWord = 16'h0000;
    logic [15:0] nvmData, cmdActive, analogLevel, serialOut;
    logic [4:0] resBits = 5'h0e;
    logic [NVM_AW-1:0] nvmAddr;
    wmfc_mode_t mode;
    int num_errors = 0, checks_done = 0, cycles = 0;
    wmfc_top #(.START_WDG(200), .MEAS_WDG(100)) uut (.clk(clk),
        .nrst(nrst), .cmdValid(cmdValid), .cmdWord(cmdWord),
        .cmdFromOneWire(cmdFromOneWire), .cmdReady(cmdReady),
        .cmdDone(cmdDone), .cmdStart(cmdStart), .cmdActive(cmdActive),
        .nvmAddr(nvmAddr), .nvmRead(nvmRead), .nvmData(nvmData),
        .nvmError(nvmError), .nvmWriteEn(nvmWriteEn), .ramRead(ramRead),
        .ramParityBad(ramParityBad), .measDone(measDone), .result(result),
        .rawTemp(rawTemp), .resBits(resBits), .sensFail(sensFail),
        .agingFail(agingFail), .romFail(romFail), .measRun(measRun),
        .analogLevel(analogLevel), .lowerFaultBand(lowerFaultBand),
        .serialOut(serialOut), .oneWireEnable(oneWireEnable),
        .i2cEnable(i2cEnable), .mode(mode));
    wmfc_core_model core (.clk(clk), .nrst(nrst), .cfgWord(cfgWord),
        .badWord(badWord), .stall(stall), .nvmAddr(nvmAddr),
        .nvmRead(nvmRead), .nvmData(nvmData), .nvmError(nvmError),
        .cmdStart(cmdStart), .cmdActive(cmdActive), .measRun(measRun),
        .lowerFaultBand(lowerFaultBand), .cmdDone(cmdDone),
        .measDone(measDone));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkm(input wmfc_mode_t m);
        chk({14'h0000, mode}, {14'h0000, m});
    endtask
    task automatic idle();
        for (int i = 0; i < 60 && mode == MODE_INIT; i++) @(negedge clk);
    endtask
    task automatic boot(input logic [15:0] cfg, input logic bad);
        nrst = 1'b0;
        cfgWord = cfg;
        badWord = bad;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        idle();
    endtask
    task automatic send(input logic [15:0] w, input logic ow);
        @(negedge clk);
        cmdValid = 1'b1;
        cmdWord = w;
        cmdFromOneWire = ow;
        for (int i = 0; i < 40 && cmdReady !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        cmdValid = 1'b0;
    endtask
    task automatic meas(input int n);
        repeat (n) begin
            for (int i = 0; i < 60; i++) begin
                @(posedge clk);
                if (measDone === 1'b1) break;
            end
        end
        repeat (3) @(negedge clk);
    endtask
    task automatic t_normal();
        result = 16'h1234;
        boot(16'h0000, 1'b0);
        chkm(MODE_NORMAL);
        meas(1);
        chk(serialOut, 16'h1234);
        chk(analogLevel, 16'h1234);
        send(CMD_NVM_UNLOCK, 1'b0);
        send(CMD_MEASURE, 1'b0);
        chkm(MODE_NORMAL);
        chk({15'h0000, measRun}, 16'h0001);
    endtask
    task automatic t_session();
        send(CMD_ENTER_SESSION, 1'b1);
        chkm(MODE_SESSION);
        chk({15'h0000, measRun}, 16'h0000);
        send(CMD_NVM_WRITE, 1'b0);
        chk({15'h0000, cmdReady}, 16'h0000);
        chk({15'h0000, nvmWriteEn}, 16'h0000);
        send(CMD_NVM_UNLOCK, 1'b0);
        send(CMD_NVM_WRITE, 1'b0);
        chk({15'h0000, nvmWriteEn}, 16'h0001);
        chk(cmdActive, CMD_NVM_WRITE);
        send(CMD_REINIT, 1'b0);
        chk({15'h0000, nvmRead}, 16'h0001);
        idle();
        chkm(MODE_NORMAL);
        send(CMD_ENTER_SESSION, 1'b0);
        send(CMD_LEAVE_SESSION, 1'b0);
        chkm(MODE_NORMAL);
        send(CMD_ENTER_SESSION, 1'b0);
        send(CMD_MEASURE, 1'b0);
        repeat (10) @(negedge clk);
        chk({15'h0000, measRun}, 16'h0001);
        chk({15'h0000, cmdReady}, 16'h0000);
    endtask
    task automatic t_nvm_err();
        boot(16'h0000, 1'b1);
        chkm(MODE_FAULT);
        @(negedge clk);
        chk(serialOut, ERR_NVM);
        chk(analogLevel, 16'h0000);
        chk({13'h0000, lowerFaultBand, oneWireEnable, i2cEnable},
            16'h0007);
        send(CMD_ENTER_SESSION, 1'b1);
        chkm(MODE_SESSION);
    endtask
    task automatic t_parity();
        boot(16'h0000, 1'b0);
        @(negedge clk);
        ramRead = 1'b1;
        ramParityBad = 1'b1;
        @(negedge clk);
        ramRead = 1'b0;
        ramParityBad = 1'b0;
        @(negedge clk);
        chkm(MODE_FAULT);
        chk(serialOut, ERR_RAM_PARITY);
        send(CMD_ENTER_SESSION, 1'b0);
        chkm(MODE_SESSION);
    endtask
    task automatic t_temp();
        rawTemp = 16'h0000;
        {sensFail, agingFail, romFail} = 3'h7;
        boot(16'h0000, 1'b0);
        meas(2);
        chkm(MODE_NORMAL);
        {sensFail, agingFail, romFail} = 3'h0;
        boot(16'h0001, 1'b0);
        meas(1);
        chkm(MODE_NORMAL);
        rawTemp = 16'hfffc;
        resBits = 5'h10;
        meas(1);
        chkm(MODE_FAULT);
        chk(serialOut, ERR_SENSOR);
        rawTemp = 16'h8000;
        meas(1);
        chkm(MODE_FAULT);
        meas(1);
        chkm(MODE_NORMAL);
    endtask
    task automatic t_watch();
        boot(16'h0000, 1'b0);
        stall = 1'b1;
        repeat (130) @(negedge clk);
        chk(serialOut, ERR_WATCHDOG);
        stall = 1'b0;
    endtask
    initial begin
        t_normal();
        t_session();
        t_nvm_err();
        t_parity();
        t_temp();
        t_watch();
        test_done();
    end
endmodule
`default_nettype wire
